// ===== hdl/ilkn_tx_pkg.sv
// shared constants and types for the transmit path control ends
package ilkn_tx_pkg;
   // ----------------------------------------------------------------
   // control word layout
   // ----------------------------------------------------------------
   localparam int CW_CAL_START_BIT = 56;
   localparam int CW_CAL_MSB = 55;
   localparam int CW_CAL_LSB = 40;
   localparam int CW_MU_MSB = 31;
   localparam int CW_MU_LSB = 24;
   localparam int CW_DIAG_FLAG_BIT = 58;
   localparam int DIAG_LANE_BIT = 33;
   localparam int DIAG_LINK_BIT = 32;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int CAL_ENTRIES = 256;
   localparam int CAL_GROUP = 16;
   localparam int CAL_WORDS = 8;
   localparam int LANES = 12;
   localparam int WORD_BITS = 64;
   localparam logic [12:0] WORD_BYTES = 13'h0008;
   // ----------------------------------------------------------------
   // timing counts in link words
   // ----------------------------------------------------------------
   localparam logic [3:0] BURST_WORDS = 4'h8;
   localparam logic [10:0] META_WORDS = 11'h800;
   // ----------------------------------------------------------------
   // register map, byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RLIM = 8'h04;
   localparam logic [7:0] REG_HEALTH = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_CAL_BASE = 8'h10;
   localparam logic [7:0] REG_CAL_LAST = 8'h2C;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_PERMIT_BIT = 0;
   localparam int CTRL_RLIM_ON_BIT = 1;
   localparam int CTRL_MU_LSB = 8;
   localparam int RLIM_MAX_LSB = 0;
   localparam int RLIM_DELTA_LSB = 16;
   localparam int HEALTH_PERIOD_LSB = 0;
   localparam int HEALTH_LINK_BIT = 8;
   localparam int HEALTH_LANE_LSB = 16;
   localparam int STAT_UNDER_BIT = 0;
   localparam int STAT_OVER_BIT = 1;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] RLIM_RESET = 32'h0000_0FFF;
   localparam logic [31:0] HEALTH_RESET = 32'h0000_0000;
   localparam logic [31:0] CAL_RESET = 32'hFFFF_FFFF;
   localparam logic [11:0] BUCKET_RESET = 12'h000;
   // ----------------------------------------------------------------
   // transmit sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_DIAG = 2'b10
   } tx_state_t;
endpackage

// ===== hdl/ilkn_tx_ctl_if.sv
// control, status and data carrier between user logic and the core
`timescale 1ns/1ns
interface ilkn_tx_ctl_if;
   logic tx_permit;
   logic [255:0] tx_calendar_xon_bits;
   logic [7:0] tx_multi_use_field;
   logic rlim_on;
   logic [11:0] rlim_max;
   logic [11:0] rlim_delta;
   logic [7:0] tx_refill_period;
   logic [11:0] tx_lane_health_bits;
   logic tx_link_health_bit;
   logic underflow;
   logic overflow;
   logic [63:0] data_word;
   logic data_valid;
   logic data_ready;
   modport core (
      input tx_permit, tx_calendar_xon_bits, tx_multi_use_field, rlim_on,
      input rlim_max, rlim_delta, tx_refill_period,
      input tx_lane_health_bits, tx_link_health_bit, data_word, data_valid,
      output underflow, overflow, data_ready
   );
   modport user (
      output tx_permit, tx_calendar_xon_bits, tx_multi_use_field, rlim_on,
      output rlim_max, rlim_delta, tx_refill_period,
      output tx_lane_health_bits, tx_link_health_bit, data_word, data_valid,
      input underflow, overflow, data_ready
   );
endinterface

// ===== hdl/tx_path_core.sv
// transmit path core: gating, calendar insertion, rate limiter, diagnostics
//
// Overview of operation
// RULE_01 - send data only while permit sampled high
// RULE_02 - permit low: only idle and framing words
// RULE_03 - user holds permit low until receiver aligned
// RULE_04 - calendar bit one is XON, in 55:40
// RULE_05 - calendar holds 256 entries, one per bit
// RULE_06 - bit 56 set marks first sixteen entries
// RULE_07 - bit 55 carries entry 0, descending after
// RULE_08 - later control words carry next sixteen
// RULE_09 - user drives calendar on the core clock
// RULE_10 - multi-use field copied into bits 31:24
// RULE_11 - unused multi-use field held at zero
// RULE_12 - limiter on when its enable is one
// RULE_13 - bucket never exceeds maximum count, bytes
// RULE_14 - add delta tokens each refill interval
// RULE_15 - interval sets cycles between token additions
// RULE_16 - lane health bit drives diag bit 33
// RULE_17 - link health bit drives diag bit 32
// RULE_18 - flag underflow when data cannot fill link
// RULE_19 - overflow flags critical failure; user resets
// RULE_20 - sent bytes drain bucket; pause when short
// RULE_21 - synchronize async health inputs before use
`timescale 1ns/1ns
module tx_path_core (
   // clock, reset, enable
   input logic i_clk_sys,
   input logic i_resetn,
   input logic i_ce,
   // user side controls and data
   ilkn_tx_ctl_if.core ctl,
   // transmit link words
   output logic o_link_valid,
   output logic [63:0] o_link_word,
   output logic o_link_ctrl,
   output logic [3:0] o_link_lane
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ilkn_tx_pkg::tx_state_t state;
   ilkn_tx_pkg::tx_state_t next_state;
   logic [10:0] meta_cnt;
   logic [10:0] next_meta_cnt;
   logic [3:0] lane_idx;
   logic [3:0] burst_cnt;
   logic [3:0] next_burst_cnt;
   logic [3:0] cal_grp;
   logic [11:0] bucket;
   logic [11:0] next_bucket;
   logic [12:0] bucket_sum;
   logic [7:0] refill_cnt;
   logic refill_tick;
   logic take;
   logic bad_state;
   logic next_ready;
   logic [63:0] next_word;
   logic next_ctrl;
   logic [15:0] cal_slice;
   logic [12:0] health_meta;
   logic [12:0] health_sync;

   // ----------------------------------------------------------------
   // health synchronizer
   // ----------------------------------------------------------------
   // first stage is read only by the second stage
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         health_meta <= 13'h0000;
         health_sync <= 13'h0000;
      end else if (i_ce) begin
         health_meta <= {ctl.tx_link_health_bit, ctl.tx_lane_health_bits}; // see RULE_21
         health_sync <= health_meta; // see RULE_21
      end
   end

   // ----------------------------------------------------------------
   // calendar slice
   // ----------------------------------------------------------------
   // entry grp*16+k lands on bit 55-k of the control word
   for (genvar k = 0; k < ilkn_tx_pkg::CAL_GROUP; k++) begin : g_cal
      assign cal_slice[15-k] = ctl.tx_calendar_xon_bits[{cal_grp, 4'(k)}]; // see RULE_07
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_comb begin
      // data is only taken while permit is sampled high
      take = ctl.data_valid & ctl.data_ready & ctl.tx_permit; // see RULE_01
      bad_state = 1'b0;
      next_state = ilkn_tx_pkg::ST_IDLE;
      unique case (state)
         ilkn_tx_pkg::ST_IDLE, ilkn_tx_pkg::ST_DATA: begin
            if (meta_cnt == ilkn_tx_pkg::META_WORDS - 11'h001) begin
               next_state = ilkn_tx_pkg::ST_DIAG;
            end else if (take) begin
               next_state = ilkn_tx_pkg::ST_DATA;
            end else begin
               next_state = ilkn_tx_pkg::ST_IDLE;
            end
         end
         ilkn_tx_pkg::ST_DIAG: begin
            if (lane_idx == 4'(ilkn_tx_pkg::LANES - 1)) begin
               next_state = ilkn_tx_pkg::ST_IDLE;
            end else begin
               next_state = ilkn_tx_pkg::ST_DIAG;
            end
         end
         default: begin
            bad_state = 1'b1;
         end
      endcase
      if (state == ilkn_tx_pkg::ST_DIAG) begin
         next_meta_cnt = 11'h000;
      end else begin
         next_meta_cnt = meta_cnt + 11'h001;
      end
      next_burst_cnt = take ? burst_cnt + 4'h1 : 4'h0;
   end

   // ----------------------------------------------------------------
   // rate limiter
   // ----------------------------------------------------------------
   always_comb begin
      // a period of zero refills every cycle
      refill_tick = ({1'b0, refill_cnt} + 9'h001) >= {1'b0, ctl.tx_refill_period}; // see RULE_15
      bucket_sum = {1'b0, bucket};
      if (refill_tick) begin
         bucket_sum = bucket_sum + {1'b0, ctl.rlim_delta}; // see RULE_14
      end
      // saturate: a wrapped difference would clamp to a full bucket
      if (take && ctl.rlim_on && bucket_sum >= ilkn_tx_pkg::WORD_BYTES) begin
         bucket_sum = bucket_sum - ilkn_tx_pkg::WORD_BYTES; // see RULE_20
      end else if (take && ctl.rlim_on) begin
         bucket_sum = 13'h0000;
      end
      // clamp also covers a maximum lowered below the fill level
      if (bucket_sum > {1'b0, ctl.rlim_max}) begin
         next_bucket = ctl.rlim_max; // see RULE_13
      end else begin
         next_bucket = bucket_sum[11:0];
      end
      next_ready = ctl.tx_permit
         & (next_state != ilkn_tx_pkg::ST_DIAG)
         & (next_meta_cnt != ilkn_tx_pkg::META_WORDS - 11'h001)
         & (next_burst_cnt != ilkn_tx_pkg::BURST_WORDS)
         & (!ctl.rlim_on | ({1'b0, next_bucket} >= ilkn_tx_pkg::WORD_BYTES)); // see RULE_12
   end

   // ----------------------------------------------------------------
   // word assembly
   // ----------------------------------------------------------------
   always_comb begin
      next_word = 64'h0000_0000_0000_0000;
      next_ctrl = 1'b1;
      if (state == ilkn_tx_pkg::ST_DIAG) begin
         next_word[ilkn_tx_pkg::CW_DIAG_FLAG_BIT] = 1'b1;
         next_word[ilkn_tx_pkg::DIAG_LANE_BIT] = health_sync[lane_idx]; // see RULE_16
         next_word[ilkn_tx_pkg::DIAG_LINK_BIT] = health_sync[12]; // see RULE_17
      end else if (take) begin
         next_word = ctl.data_word;
         next_ctrl = 1'b0;
      end else begin
         // permit low ends up here in every cycle outside ST_DIAG: idle words only
         next_word[ilkn_tx_pkg::CW_CAL_START_BIT] = (cal_grp == 4'h0); // see RULE_06
         next_word[ilkn_tx_pkg::CW_CAL_MSB:ilkn_tx_pkg::CW_CAL_LSB] = cal_slice; // see RULE_04
         next_word[ilkn_tx_pkg::CW_MU_MSB:ilkn_tx_pkg::CW_MU_LSB] =
            ctl.tx_multi_use_field; // see RULE_10
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ilkn_tx_pkg::ST_IDLE;
         meta_cnt <= 11'h000;
         lane_idx <= 4'h0;
         burst_cnt <= 4'h0;
      end else if (i_ce) begin
         state <= next_state;
         meta_cnt <= next_meta_cnt;
         burst_cnt <= next_burst_cnt;
         if (state == ilkn_tx_pkg::ST_DIAG) begin
            lane_idx <= lane_idx + 4'h1;
         end else begin
            lane_idx <= 4'h0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cal_grp <= 4'h0;
      end else if (i_ce && state != ilkn_tx_pkg::ST_DIAG && !take) begin
         // 16 groups of 16 walk the full 256 entry calendar
         cal_grp <= cal_grp + 4'h1; // see RULE_08, RULE_05
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         bucket <= ilkn_tx_pkg::BUCKET_RESET;
         refill_cnt <= 8'h00;
      end else if (i_ce) begin
         bucket <= next_bucket;
         refill_cnt <= refill_tick ? 8'h00 : refill_cnt + 8'h01;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl.data_ready <= 1'b0;
      end else if (i_ce) begin
         ctl.data_ready <= next_ready; // see RULE_20
      end
   end

   // ----------------------------------------------------------------
   // error flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl.underflow <= 1'b0;
         ctl.overflow <= 1'b0;
      end else if (i_ce) begin
         // open burst, slot offered, no word ready: link starves
         ctl.underflow <= !take && (burst_cnt != 4'h0) && ctl.data_ready
            && ctl.tx_permit; // see RULE_18
         // sticky: only a reset clears it, though the state itself returns to ST_IDLE
         if (bad_state) begin
            ctl.overflow <= 1'b1; // see RULE_19
         end
      end
   end

   // ----------------------------------------------------------------
   // link outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_link_valid <= 1'b0;
         o_link_word <= 64'h0000_0000_0000_0000;
         o_link_ctrl <= 1'b0;
         o_link_lane <= 4'h0;
      end else if (i_ce) begin
         o_link_valid <= 1'b1;
         o_link_word <= next_word; // see RULE_02
         o_link_ctrl <= next_ctrl;
         o_link_lane <= lane_idx;
      end
   end
endmodule

// ===== hdl/tx_path_user.sv
// user side: APB register file driving the core controls and data
`timescale 1ns/1ns
module tx_path_user (
   // clock, reset, enable
   input logic i_clk_sys,
   input logic i_resetn,
   input logic i_ce,
   // APB slave
   input logic i_psel,
   input logic i_penable,
   input logic i_pwrite,
   input logic [7:0] i_paddr,
   input logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // user data words
   input logic [63:0] i_data,
   input logic i_data_valid,
   output logic o_data_ready,
   // core side
   ilkn_tx_ctl_if.user ctl
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_reg;
   logic [31:0] rlim_reg;
   logic [31:0] health_reg;
   logic [31:0] cal_mem [0:ilkn_tx_pkg::CAL_WORDS-1];
   logic under_sticky;
   logic wr_en;
   logic acc;
   logic cal_hit;
   logic [2:0] cal_idx;
   logic [31:0] next_rdata;
   logic next_err;
   logic next_sv;

   always_comb begin
      acc = i_psel & i_penable & !o_pready;
      wr_en = i_psel & i_penable & o_pready & i_pwrite;
      cal_hit = (i_paddr >= ilkn_tx_pkg::REG_CAL_BASE)
         & (i_paddr <= ilkn_tx_pkg::REG_CAL_LAST) & (i_paddr[1:0] == 2'h0);
      cal_idx = 3'((i_paddr - ilkn_tx_pkg::REG_CAL_BASE) >> 2);
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (cal_hit) begin
         next_rdata = cal_mem[cal_idx];
      end else begin
         unique case (i_paddr)
            ilkn_tx_pkg::REG_CTRL: next_rdata = ctrl_reg;
            ilkn_tx_pkg::REG_RLIM: next_rdata = rlim_reg;
            ilkn_tx_pkg::REG_HEALTH: next_rdata = health_reg;
            ilkn_tx_pkg::REG_STATUS: begin
               next_rdata[ilkn_tx_pkg::STAT_UNDER_BIT] = under_sticky;
               next_rdata[ilkn_tx_pkg::STAT_OVER_BIT] = ctl.overflow;
            end
            default: next_err = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   // one wait state keeps pready and prdata on flip-flops
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_ce) begin
         o_pready <= acc;
         o_prdata <= (acc && !i_pwrite) ? next_rdata : 32'h0000_0000;
         o_pslverr <= acc & next_err;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= ilkn_tx_pkg::CTRL_RESET;
         rlim_reg <= ilkn_tx_pkg::RLIM_RESET;
         health_reg <= ilkn_tx_pkg::HEALTH_RESET;
      end else if (i_ce && wr_en) begin
         if (i_paddr == ilkn_tx_pkg::REG_CTRL) begin
            ctrl_reg <= i_pwdata & 32'h0000_FF03;
         end
         if (i_paddr == ilkn_tx_pkg::REG_RLIM) begin
            rlim_reg <= i_pwdata & 32'h0FFF_0FFF;
         end
         if (i_paddr == ilkn_tx_pkg::REG_HEALTH) begin
            health_reg <= i_pwdata & 32'h0FFF_01FF;
         end
      end
   end

   for (genvar i = 0; i < ilkn_tx_pkg::CAL_WORDS; i++) begin : g_cal
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
         if (!i_resetn) begin
            cal_mem[i] <= ilkn_tx_pkg::CAL_RESET;
         end else if (i_ce && wr_en && cal_hit && cal_idx == 3'(i)) begin
            cal_mem[i] <= i_pwdata;
         end
      end
      // calendar changes on this clock only, apart from the asynchronous reset to all ones
      assign ctl.tx_calendar_xon_bits[32*i +: 32] = cal_mem[i]; // see RULE_09
   end

   // hardware set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         under_sticky <= 1'b0;
      end else if (i_ce) begin
         if (ctl.underflow) begin
            under_sticky <= 1'b1;
         end else if (wr_en && i_paddr == ilkn_tx_pkg::REG_STATUS
                      && i_pwdata[ilkn_tx_pkg::STAT_UNDER_BIT]) begin
            under_sticky <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // controls toward the core
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl.tx_permit <= 1'b0;
         ctl.rlim_on <= 1'b0;
         ctl.tx_multi_use_field <= 8'h00;
         ctl.rlim_max <= 12'h000;
         ctl.rlim_delta <= 12'h000;
         ctl.tx_refill_period <= 8'h00;
         ctl.tx_lane_health_bits <= 12'h000;
         ctl.tx_link_health_bit <= 1'b0;
      end else if (i_ce) begin
         // software raises permit once the far receiver is aligned
         ctl.tx_permit <= ctrl_reg[ilkn_tx_pkg::CTRL_PERMIT_BIT]; // see RULE_03
         ctl.rlim_on <= ctrl_reg[ilkn_tx_pkg::CTRL_RLIM_ON_BIT];
         // resets to zero so an unused field goes out as zero
         ctl.tx_multi_use_field <= ctrl_reg[ilkn_tx_pkg::CTRL_MU_LSB +: 8]; // see RULE_11
         ctl.rlim_max <= rlim_reg[ilkn_tx_pkg::RLIM_MAX_LSB +: 12];
         ctl.rlim_delta <= rlim_reg[ilkn_tx_pkg::RLIM_DELTA_LSB +: 12];
         ctl.tx_refill_period <= health_reg[ilkn_tx_pkg::HEALTH_PERIOD_LSB +: 8];
         ctl.tx_lane_health_bits <= health_reg[ilkn_tx_pkg::HEALTH_LANE_LSB +: 12];
         ctl.tx_link_health_bit <= health_reg[ilkn_tx_pkg::HEALTH_LINK_BIT];
      end
   end

   // ----------------------------------------------------------------
   // one word data stage
   // ----------------------------------------------------------------
   always_comb begin
      if (ctl.data_valid) begin
         // the core takes only while permit is high as well
         next_sv = !(ctl.data_ready & ctl.tx_permit);
      end else begin
         next_sv = i_data_valid & o_data_ready;
      end
   end

   // a single stage halves throughput at best; kept for flop outputs
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl.data_valid <= 1'b0;
         ctl.data_word <= 64'h0000_0000_0000_0000;
         o_data_ready <= 1'b0;
      end else if (i_ce) begin
         ctl.data_valid <= next_sv;
         o_data_ready <= !next_sv;
         if (!ctl.data_valid && i_data_valid && o_data_ready) begin
            ctl.data_word <= i_data;
         end
      end
   end
endmodule

// ===== bench/ilkn_tx_sva.sv
// checker on the carrier and link words between the two ends
`timescale 1ns/1ns
module ilkn_tx_sva (
   // clock, reset and carrier
   input logic i_clk_sys,
   input logic i_resetn,
   input logic tx_permit,
   input logic [7:0] tx_multi_use_field,
   input logic data_valid,
   input logic data_ready,
   input logic overflow,
   // link words
   input logic o_link_valid,
   input logic [63:0] o_link_word,
   input logic o_link_ctrl,
   input logic [3:0] o_link_lane
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   logic [3:0] grp;
   wire take = data_valid && data_ready && tx_permit;
   wire cw = o_link_valid && o_link_ctrl && !o_link_word[58];
   // diag words carry no calendar, so they leave the group alone
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) grp <= 4'h0;
      else if (cw) grp <= grp + 4'h1;
   end
   sequence s_diag_mid;
      o_link_ctrl && o_link_word[58] && o_link_lane < 4'hB;
   endsequence
   a_take_sends_data: assert property (
      take |=> o_link_valid && !o_link_ctrl) else $error("take not sent");
   a_data_needs_take: assert property (
      o_link_valid && !o_link_ctrl |-> $past(take)) else $error("data without take");
   a_idle_sends_ctrl: assert property (
      o_link_valid && !take |=> o_link_ctrl) else $error("data while idle");
   a_cal_first_mark: assert property (
      cw |-> o_link_word[56] == (grp == 4'h0)) else $error("calendar start bit wrong");
   a_multi_use_copy: assert property (
      cw |-> o_link_word[31:24] == $past(tx_multi_use_field)) else $error("multi-use wrong");
   a_diag_lane_step: assert property (
      s_diag_mid |=> o_link_word[58] && o_link_lane == $past(o_link_lane) + 4'h1)
      else $error("diag lane order wrong");
   a_diag_lane_range: assert property (
      o_link_ctrl && o_link_word[58] |-> o_link_lane < 4'hC) else $error("diag lane range");
   a_no_overflow: assert property (
      !overflow) else $error("overflow raised");
endmodule

// ===== bench/tb_top.sv
// self-checking bench: user end and core end joined by the carrier
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0, dval = 1'b0;
   logic rdy, err, drdy, lv, lc, perr;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [63:0] dat = 64'h0, lw, seen [$];
   logic [3:0] ll;
   localparam logic [63:0] W0 = 64'h0123_4567_89AB_CD00;
   int fails = 0, n_tests = 0, cyc = 0;
   ilkn_tx_ctl_if bus ();
   tx_path_user tx_path_user_i (.i_clk_sys(clk), .i_resetn(rst_n), .i_ce(1'b1), .i_psel(sel),
      .i_penable(en), .i_pwrite(wr), .i_paddr(addr), .i_pwdata(wdata), .o_pready(rdy),
      .o_prdata(rdata), .o_pslverr(err), .i_data(dat), .i_data_valid(dval),
      .o_data_ready(drdy), .ctl(bus.user));
   tx_path_core tx_path_core_i (.i_clk_sys(clk), .i_resetn(rst_n), .i_ce(1'b1), .ctl(bus.core),
      .o_link_valid(lv), .o_link_word(lw), .o_link_ctrl(lc), .o_link_lane(ll));
   ilkn_tx_sva ilkn_tx_sva_i (.i_clk_sys(clk), .i_resetn(rst_n), .tx_permit(bus.tx_permit),
      .tx_multi_use_field(bus.tx_multi_use_field), .data_valid(bus.data_valid),
      .data_ready(bus.data_ready), .overflow(bus.overflow), .o_link_valid(lv),
      .o_link_word(lw), .o_link_ctrl(lc), .o_link_lane(ll));
   initial forever #2 clk = ~clk;
   task automatic stop_test();
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [63:0] s, input logic [63:0] e, input string n);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      en <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      {perr, rd} = {err, rdata};
      sel <= 1'b0;
      en <= 1'b0;
   endtask
   task automatic push(input logic [63:0] d);
      dat <= d;
      dval <= 1'b1;
      do @(posedge clk); while (drdy !== 1'b1);
      dval <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_gate();
      apb(1'b1, 8'h10, 32'h0000_A5C3);
      apb(1'b1, 8'h00, 32'h0000_5A00);
      push(W0);
      repeat (20) @(posedge clk);
      check(seen.size(), 0, "held");
      do @(posedge clk); while (!(lc === 1'b1 && lw[58] === 1'b0 && lw[56] === 1'b1));
      // entry 0 leads at bit 55, so the pattern comes out bit-reversed
      check({lw[55:40], lw[31:24]}, 24'hC3A55A, "control");
      @(posedge clk);
      check(lw[56:40], 17'h0_0000, "group 1");
      @(posedge clk);
      check(lw[56:40], 17'h0_FFFF, "group 2");
      apb(1'b1, 8'h00, 32'h0000_5A01);
      for (int k = 1; k < 13; k++) push(W0 + k);
      repeat (10) @(posedge clk);
      for (int k = 0; k < 13; k++) check(seen.pop_front(), W0 + k, "data");
   endtask
   task automatic t_rlim();
      int t0;
      apb(1'b0, 8'h04, 32'h0);
      check(rd, ilkn_tx_pkg::RLIM_RESET, "limit reset");
      apb(1'b1, 8'h04, 32'h0000_0010);
      apb(1'b1, 8'h00, 32'h0000_5A03);
      // the limiter enable reaches the core one cycle after the write
      @(posedge clk);
      push(W0);
      repeat (40) @(posedge clk);
      check(seen.size(), 0, "empty bucket");
      apb(1'b1, 8'h08, 32'h0A5C_0108);
      apb(1'b1, 8'h04, 32'h0008_0010);
      repeat (40) @(posedge clk);
      check(seen.pop_front(), W0, "refill");
      t0 = cyc;
      for (int k = 0; k < 6; k++) push(W0 + k);
      while (seen.size() < 6) @(posedge clk);
      // a full bucket covers two words, the rest wait 8 cycles per 8 tokens
      check(cyc - t0 >= 24, 1, "pacing");
      apb(1'b1, 8'h00, 32'h0000_5A01);
   endtask
   task automatic t_diag();
      do @(posedge clk); while (!(lc === 1'b1 && lw[58] === 1'b1 && ll === 4'h0));
      check(lw[33:32], 2'b01, "lane 0 health");
      do @(posedge clk); while (!(lc === 1'b1 && lw[58] === 1'b1 && ll === 4'h2));
      check(lw[33:32], 2'b11, "lane 2 health");
      apb(1'b0, 8'h0C, 32'h0);
      check(rd[1:0], 2'b01, "status");
      apb(1'b1, 8'h0C, 32'h0000_0001);
      apb(1'b0, 8'h0C, 32'h0);
      check(rd[1:0], 2'b00, "status clear");
      apb(1'b0, 8'h30, 32'h0);
      check({perr, rd}, 33'h1_0000_0000, "unmapped");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (lv === 1'b1 && lc === 1'b0) seen.push_back(lw);
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_gate();
      t_rlim();
      t_diag();
      stop_test();
   end
endmodule
